/* File: asd_cfg.svh */
/*
 * Constants for the ADC setup/configuration decode block: command byte
 * prefixes, field positions, power-up values, byte length and temperature offset.
 * Assumes inclusion by bare name from the package and design modules.
 */
`ifndef ASD_CFG_SVH
`define ASD_CFG_SVH

// command byte prefixes (compared against the top bits of a byte)
`define ASD_CONV_PFX 1'h1
`define ASD_SETUP_PFX 2'h1
`define ASD_AVG_PFX 3'h1
`define ASD_RESET_PFX 4'h1

// field positions inside the command bytes
`define ASD_SETUP_CK_HI 5
`define ASD_SETUP_CK_LO 4
`define ASD_SETUP_REF_HI 3
`define ASD_SETUP_REF_LO 2
`define ASD_SETUP_DIFF_HI 1
`define ASD_SETUP_DIFF_LO 0
`define ASD_AVG_ON_BIT 4
`define ASD_RESET_TYPE_BIT 3

// power-up values
`define ASD_SETUP_RST 8'h20
`define ASD_REG_RST 8'h00

// bits per command byte
`define ASD_BYTE_BITS 4'h8

// Kelvin to Celsius at 1/8 degree per code: 273.15 * 8
`define ASD_TEMP_OFFSET 12'h889

`endif

/* File: asd_pkg.sv */
/*
 * Types for the ADC setup/configuration decode block.
 * Assumes asd_cfg.svh is on the include path.
 */
`include "asd_cfg.svh"

package asd_pkg;

    typedef enum logic [1:0] {
        ASD_CK_INT_START = 2'b00,
        ASD_CK_INT_EXTACQ = 2'b01,
        ASD_CK_INT_AUTO = 2'b10,
        ASD_CK_SERIAL = 2'b11
    } asd_clk_mode_t;

    typedef enum logic [1:0] {
        ASD_REF_INT_PULSED = 2'b00,
        ASD_REF_EXT_SINGLE = 2'b01,
        ASD_REF_INT_ON = 2'b10,
        ASD_REF_EXT_DIFF = 2'b11
    } asd_ref_mode_t;

    typedef enum logic [1:0] {
        ASD_DIFF_NONE0 = 2'b00,
        ASD_DIFF_NONE1 = 2'b01,
        ASD_DIFF_UNI = 2'b10,
        ASD_DIFF_BIP = 2'b11
    } asd_diff_sel_t;

    // what the next complete byte of the frame is taken as
    typedef enum logic [1:0] {
        ASD_ST_CMD = 2'b00,
        ASD_ST_UNI = 2'b01,
        ASD_ST_BIP = 2'b10
    } asd_state_t;

    typedef struct packed {
        logic [1:0] pfx;
        asd_clk_mode_t clk_mode;
        asd_ref_mode_t ref_mode;
        asd_diff_sel_t diff_sel;
    } asd_setup_t;

    typedef struct packed {
        logic avg_sel;
        logic averaging_enable;
        logic [1:0] navg;
        logic [1:0] nscan;
    } asd_avg_t;

    typedef struct packed {
        logic [3:0] chan;
        logic [1:0] scan;
        logic temp;
    } asd_conv_t;

    // serial pins as one group
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic din;
    } asd_serial_t;

endpackage : asd_pkg

/* File: asd_sync.sv */
/*
 * Two-flop synchroniser for a group of asynchronous levels.
 * Assumes inputs are quasi-static relative to i_ref_clk.
 */
`timescale 1ns/1ns
module asd_sync #(
    parameter int W = 1
) (
    // clock, reset, enable
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // levels
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_r;

    // first stage feeds only the second
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            meta_r <= '0;
            o_sync <= '0;
        end else if (i_ce) begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule : asd_sync

/* File: asd_fmt.sv */
/*
 * Result word formatter: conversion codes and temperature codes into the
 * 16-bit words shifted out MSB first by the readout logic.
 * Assumes result strobes come from logic on i_ref_clk.
 */
`timescale 1ns/1ns
`include "asd_cfg.svh"
module asd_fmt
    import asd_pkg::*;
(
    // clock, reset, enable
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // conversion result: 10-bit code plus two sub-bits, offset binary
    input wire logic i_conv_valid,
    input wire logic [11:0] i_conv_code,
    input wire logic i_conv_bipolar,
    // temperature: high-bias and low-bias conversions
    input wire logic i_temp_valid,
    input wire logic [11:0] i_temp_hi,
    input wire logic [11:0] i_temp_lo,
    // formatted word
    output logic [15:0] o_word,
    output logic o_word_valid
);
    logic [11:0] temp_code;
    logic [11:0] conv_code;

    // high minus low gives Kelvin in 1/8 degree, offset takes it to C
    assign temp_code = i_temp_hi - i_temp_lo - `ASD_TEMP_OFFSET;
    // bipolar: flip MSB of offset binary to get two's complement
    assign conv_code = {i_conv_code[11] ^ i_conv_bipolar,
                        i_conv_code[10:0]};

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_word <= 16'h0000;
            o_word_valid <= 1'b0;
        end else if (i_ce) begin
            o_word_valid <= i_conv_valid | i_temp_valid;
            if (i_temp_valid) begin
                o_word <= {4'h0, temp_code};
            end else if (i_conv_valid) begin
                o_word <= {4'h0, conv_code};
            end
        end
    end
endmodule : asd_fmt

/* File: asd_setup_decode.sv */
/*
 * Serial configuration decode for a multichannel ADC: byte assembly from
 * the serial pins, setup/averaging/conversion/reset command decode, pair
 * registers, mode decode outputs and result formatting.
 * Assumes serial pins are asynchronous, sampled by a 20 MHz i_ref_clk, and
 * the serial clock is well below half that rate.
 */
// Function
// - byte with bit7=0, bit6=1 writes the setup register
// - clock mode 00: internal clock, internal acquisition, pin is start input
// - clock mode 01: internal clock, acquisition timed by start pin low time
// - mode 10 internal auto, pin analog; 11 serial clock times everything
// - reference 00: internal, off after scan, wake-up delay, pin analog
// - reference 10: internal reference always on, no wake-up delay
// - 01 external single-ended, 11 external differential; no wake-up delay
// - pair select 00/01: no follow-on byte, pair registers unchanged
// - pair select 10: next byte goes to unipolar pair register
// - pair select 11: next byte goes to bipolar pair register
// - averaging applies in every scan mode when enable bit is set
// - serial-clocked mode 11 disables averaging
// - scan mode 10 repeats conversions of one channel
// - reset command with type bit 1 empties the FIFO only
// - reset command with type bit 0 restores full power-up state
// - power-up: all blocks shut down, registers zero, setup clock mode 10
// - temperature is high-bias minus low-bias conversion, minus Celsius offset
// - temperature resolution is one eighth degree per code
// - conversion word: four zeros, 10-bit code MSB first, two sub-bits
// - temperature word: four zeros then 12-bit code
// - unipolar register bit7..0 map pairs 0/1..14/15 as unipolar
// - bipolar register bit7..0 map pairs 0/1..14/15 as bipolar
// - pair enabled in both registers is treated as unipolar
// - unipolar results straight binary, bipolar results two's complement
// - byte with bits 7..5 zero, bit4 one is a reset command
`timescale 1ns/1ns
`include "asd_cfg.svh"
module asd_setup_decode
    import asd_pkg::*;
(
    // clock, reset, enable
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // serial port pins
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_din,
    // clock-mode decode
    output logic o_int_conv_clock,
    output logic o_int_acq_timed,
    output logic o_start_pin_is_start,
    output logic o_sclk_conv_clock,
    // reference decode
    output logic o_ref_internal,
    output logic o_ref_powered,
    output logic o_ref_wake_needed,
    output logic o_ref_neg_is_ref,
    // averaging and scan decode
    output logic o_avg_active,
    output logic [1:0] o_avg_count_sel,
    output logic [1:0] o_scan_count_sel,
    output logic o_repeat_single,
    output logic [1:0] o_scan_mode,
    output logic [3:0] o_scan_chan,
    output logic o_temp_req,
    output logic o_conv_req,
    // pair configuration
    output logic [7:0] o_unipolar_pairs,
    output logic [7:0] o_bipolar_pairs,
    // reset actions
    output logic o_fifo_clear,
    output logic o_soft_reset,
    // raw register views
    output logic [7:0] o_setup_config,
    output logic [7:0] o_avg_config,
    // result input and formatted word
    input wire logic i_conv_valid,
    input wire logic [11:0] i_conv_code,
    input wire logic [3:0] i_conv_chan,
    input wire logic i_temp_valid,
    input wire logic [11:0] i_temp_hi,
    input wire logic [11:0] i_temp_lo,
    output logic [15:0] o_word,
    output logic o_word_valid
);
    asd_serial_t pins_async;
    asd_serial_t pins_s;
    logic sclk_d_r;
    logic sclk_rise;
    logic [7:0] shift_r;
    logic [7:0] shift_nxt;
    logic [3:0] bit_cnt_r;
    logic byte_done;
    asd_state_t state_r;
    asd_state_t state_nxt;
    asd_setup_t setup_r;
    asd_avg_t avg_r;
    asd_conv_t conv_r;
    logic [7:0] uni_r;
    logic [7:0] bip_r;
    logic [7:0] bip_eff;
    logic is_conv;
    logic is_setup;
    logic is_avg;
    logic is_reset;
    logic full_reset;
    logic conv_bipolar;

    assign pins_async = '{cs_n: i_cs_n, sclk: i_sclk, din: i_din};

    asd_sync #(
        .W(3)
    ) u_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_async(pins_async),
        .o_sync(pins_s)
    );

    // serial clock edge detect on the synchronised copy
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            sclk_d_r <= 1'b0;
        end else if (i_ce) begin
            sclk_d_r <= pins_s.sclk;
        end
    end

    assign sclk_rise = pins_s.sclk & ~sclk_d_r & ~pins_s.cs_n;
    assign shift_nxt = {shift_r[6:0], pins_s.din};
    // a byte counts only once its eighth bit is in
    assign byte_done = sclk_rise && (bit_cnt_r == `ASD_BYTE_BITS - 4'h1);

    // byte assembly, MSB first, restarted by every chip-select high
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            shift_r <= 8'h00;
            bit_cnt_r <= 4'h0;
        end else if (i_ce) begin
            if (pins_s.cs_n) begin
                bit_cnt_r <= 4'h0;
            end else if (sclk_rise) begin
                shift_r <= shift_nxt;
                if (byte_done) begin
                    bit_cnt_r <= 4'h0;
                end else begin
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                end
            end
        end
    end

    // command prefix decode on the completed byte
    assign is_conv = shift_nxt[7] == `ASD_CONV_PFX;
    assign is_setup = shift_nxt[7:6] == `ASD_SETUP_PFX;
    assign is_avg = shift_nxt[7:5] == `ASD_AVG_PFX;
    assign is_reset = shift_nxt[7:4] == `ASD_RESET_PFX;
    assign full_reset = byte_done && state_r == ASD_ST_CMD && is_reset
                        && !shift_nxt[`ASD_RESET_TYPE_BIT];

    // follow-on byte sequencing
    always_comb begin
        state_nxt = state_r;
        if (byte_done) begin
            state_nxt = ASD_ST_CMD;
            if (state_r == ASD_ST_CMD && is_setup) begin
                case (asd_diff_sel_t'(shift_nxt[1:0]))
                    ASD_DIFF_UNI: state_nxt = ASD_ST_UNI;
                    ASD_DIFF_BIP: state_nxt = ASD_ST_BIP;
                    default: state_nxt = ASD_ST_CMD;
                endcase
            end
        end
    end

    // pending pair byte is dropped when the frame ends
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            state_r <= ASD_ST_CMD;
        end else if (i_ce) begin
            if (pins_s.cs_n) begin
                state_r <= ASD_ST_CMD;
            end else begin
                state_r <= state_nxt;
            end
        end
    end

    // setup register; full reset goes back to clock mode 10
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || (i_ce && full_reset)) begin
            setup_r <= asd_setup_t'(`ASD_SETUP_RST);
        end else if (i_ce && byte_done && state_r == ASD_ST_CMD
                     && is_setup) begin
            setup_r <= asd_setup_t'(shift_nxt);
        end
    end

    // unipolar pair register; only a follow-on byte writes it
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || (i_ce && full_reset)) begin
            uni_r <= `ASD_REG_RST;
        end else if (i_ce && byte_done && state_r == ASD_ST_UNI) begin
            uni_r <= shift_nxt;
        end
    end

    // bipolar pair register
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || (i_ce && full_reset)) begin
            bip_r <= `ASD_REG_RST;
        end else if (i_ce && byte_done && state_r == ASD_ST_BIP) begin
            bip_r <= shift_nxt;
        end
    end

    // averaging register
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || (i_ce && full_reset)) begin
            avg_r <= asd_avg_t'(6'(`ASD_REG_RST));
        end else if (i_ce && byte_done && state_r == ASD_ST_CMD
                     && is_avg) begin
            avg_r <= asd_avg_t'(shift_nxt[5:0]);
        end
    end

    // conversion register and its one-cycle request strobe
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || (i_ce && full_reset)) begin
            conv_r <= asd_conv_t'(7'h00);
            o_conv_req <= 1'b0;
        end else if (i_ce) begin
            o_conv_req <= 1'b0;
            if (byte_done && state_r == ASD_ST_CMD && is_conv) begin
                conv_r <= asd_conv_t'(shift_nxt[6:0]);
                o_conv_req <= 1'b1;
            end
        end
    end

    // reset-command strobes for the FIFO and the other blocks
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_fifo_clear <= 1'b0;
            o_soft_reset <= 1'b0;
        end else if (i_ce) begin
            o_fifo_clear <= byte_done && state_r == ASD_ST_CMD && is_reset
                            && shift_nxt[`ASD_RESET_TYPE_BIT];
            // full reset raises only o_soft_reset; o_fifo_clear stays low
            o_soft_reset <= full_reset;
        end
    end

    // clock-mode decode
    always_comb begin
        o_int_conv_clock = setup_r.clk_mode != ASD_CK_SERIAL;
        o_int_acq_timed = 1'b0;
        o_start_pin_is_start = 1'b0;
        o_sclk_conv_clock = 1'b0;
        case (setup_r.clk_mode)
            ASD_CK_INT_START: begin
                o_int_acq_timed = 1'b1;
                o_start_pin_is_start = 1'b1;
            end
            ASD_CK_INT_EXTACQ: begin
                o_start_pin_is_start = 1'b1;
            end
            ASD_CK_INT_AUTO: begin
                o_int_acq_timed = 1'b1;
            end
            default: begin
                o_sclk_conv_clock = 1'b1;
            end
        endcase
    end

    // reference decode; mode 00 at power-up leaves the reference off
    always_comb begin
        o_ref_internal = 1'b0;
        o_ref_powered = 1'b0;
        o_ref_wake_needed = 1'b0;
        o_ref_neg_is_ref = 1'b0;
        case (setup_r.ref_mode)
            ASD_REF_INT_PULSED: begin
                o_ref_internal = 1'b1;
                o_ref_wake_needed = 1'b1;
            end
            ASD_REF_INT_ON: begin
                o_ref_internal = 1'b1;
                o_ref_powered = 1'b1;
            end
            ASD_REF_EXT_DIFF: begin
                o_ref_neg_is_ref = 1'b1;
            end
            default: begin
                o_ref_neg_is_ref = 1'b0;
            end
        endcase
    end

    // averaging is meaningless when the host clocks each conversion
    assign o_avg_active = avg_r.averaging_enable
                          && setup_r.clk_mode != ASD_CK_SERIAL;
    assign o_avg_count_sel = avg_r.navg;
    assign o_scan_count_sel = avg_r.nscan;
    assign o_scan_mode = conv_r.scan;
    assign o_scan_chan = conv_r.chan;
    assign o_temp_req = conv_r.temp;
    assign o_repeat_single = conv_r.scan == 2'b10;

    // unipolar wins where a pair is set in both
    assign bip_eff = bip_r & ~uni_r;
    assign o_unipolar_pairs = uni_r;
    assign o_bipolar_pairs = bip_eff;
    assign o_setup_config = setup_r;
    assign o_avg_config = {2'b00, avg_r};

    // pair 0/1 sits in bit 7, so index from the top
    assign conv_bipolar = bip_eff[3'h7 - i_conv_chan[3:1]];

    asd_fmt u_fmt (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_conv_valid(i_conv_valid),
        .i_conv_code(i_conv_code),
        .i_conv_bipolar(conv_bipolar),
        .i_temp_valid(i_temp_valid),
        .i_temp_hi(i_temp_hi),
        .i_temp_lo(i_temp_lo),
        .o_word(o_word),
        .o_word_valid(o_word_valid)
    );
endmodule : asd_setup_decode

/* File: asd_setup_decode_asserts.sv */
/*
 * Checker for asd_setup_decode: mode decode, pair precedence, reset
 * values, reset strobes and result words.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ns
`include "asd_cfg.svh"
module asd_setup_decode_asserts (
    // clock, reset, enable
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // results in
    input wire logic i_conv_valid,
    input wire logic [11:0] i_conv_code,
    input wire logic i_temp_valid,
    input wire logic [11:0] i_temp_hi,
    input wire logic [11:0] i_temp_lo,
    // decode outputs
    input wire logic o_int_conv_clock,
    input wire logic o_int_acq_timed,
    input wire logic o_start_pin_is_start,
    input wire logic o_sclk_conv_clock,
    input wire logic o_ref_internal,
    input wire logic o_ref_powered,
    input wire logic o_ref_wake_needed,
    input wire logic o_ref_neg_is_ref,
    input wire logic o_avg_active,
    // registers and strobes
    input wire logic [7:0] o_unipolar_pairs,
    input wire logic [7:0] o_bipolar_pairs,
    input wire logic o_fifo_clear,
    input wire logic o_soft_reset,
    input wire logic [7:0] o_setup_config,
    input wire logic [7:0] o_avg_config,
    input wire logic [15:0] o_word,
    input wire logic o_word_valid
);
    logic [1:0] ck;
    logic [1:0] rf;
    assign ck = o_setup_config[5:4];
    assign rf = o_setup_config[3:2];
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    property p_clk_src;
        o_sclk_conv_clock == (ck == 2'b11) && o_int_conv_clock == (ck != 2'b11);
    endproperty
    a_clk_src: assert property (p_clk_src)
        else $error("conversion clock source wrong for clock mode");
    property p_start_pin;
        o_start_pin_is_start == !ck[1] && o_int_acq_timed == !ck[0];
    endproperty
    a_start_pin: assert property (p_start_pin)
        else $error("start pin or acquisition timing wrong");
    property p_ref_wake;
        o_ref_wake_needed == (rf == 2'b00) && o_ref_internal == !rf[0];
    endproperty
    a_ref_wake: assert property (p_ref_wake)
        else $error("internal reference or wake-up flag wrong");
    property p_ref_on;
        o_ref_powered == (rf == 2'b10);
    endproperty
    a_ref_on: assert property (p_ref_on)
        else $error("reference always-on flag wrong");
    property p_ref_ext;
        o_ref_neg_is_ref == (rf == 2'b11);
    endproperty
    a_ref_ext: assert property (p_ref_ext)
        else $error("negative reference pin use wrong");
    property p_avg;
        o_avg_active == (o_avg_config[4] && ck != 2'b11);
    endproperty
    a_avg: assert property (p_avg)
        else $error("averaging active flag wrong");
    property p_pair_prec;
        (o_bipolar_pairs & o_unipolar_pairs) == 8'h00;
    endproperty
    a_pair_prec: assert property (p_pair_prec)
        else $error("pair both unipolar and bipolar");
    property p_clear_pulse;
        o_fifo_clear |-> !o_soft_reset ##1 !o_fifo_clear;
    endproperty
    a_clear_pulse: assert property (p_clear_pulse)
        else $error("fifo clear strobe malformed");
    property p_soft;
        o_soft_reset |-> o_setup_config == `ASD_SETUP_RST
            && o_unipolar_pairs == 8'h00 && o_avg_config == 8'h00;
    endproperty
    a_soft: assert property (p_soft)
        else $error("registers not restored with soft reset");
    // reset itself is the antecedent, so no disable here
    property p_por;
        @(posedge i_ref_clk) disable iff (1'b0)
        i_rst && i_ce |=> o_setup_config == `ASD_SETUP_RST
            && o_unipolar_pairs == 8'h00 && !o_word_valid;
    endproperty
    a_por: assert property (p_por)
        else $error("power-up register values wrong");
    property p_temp;
        i_temp_valid && i_ce |=> o_word_valid && o_word == {4'h0,
            $past(i_temp_hi) - $past(i_temp_lo) - `ASD_TEMP_OFFSET};
    endproperty
    a_temp: assert property (p_temp)
        else $error("temperature word wrong");
    property p_conv;
        i_conv_valid && !i_temp_valid && i_ce |=> o_word_valid
            && o_word[15:12] == 4'h0 && o_word[10:0] == $past(i_conv_code[10:0]);
    endproperty
    a_conv: assert property (p_conv)
        else $error("conversion word wrong");
endmodule : asd_setup_decode_asserts

bind asd_setup_decode asd_setup_decode_asserts asd_setup_decode_asserts_inst (
    .i_ref_clk, .i_rst, .i_ce, .i_conv_valid, .i_conv_code, .i_temp_valid,
    .i_temp_hi, .i_temp_lo, .o_int_conv_clock, .o_int_acq_timed,
    .o_start_pin_is_start, .o_sclk_conv_clock, .o_ref_internal,
    .o_ref_powered, .o_ref_wake_needed, .o_ref_neg_is_ref, .o_avg_active,
    .o_unipolar_pairs, .o_bipolar_pairs, .o_fifo_clear, .o_soft_reset,
    .o_setup_config, .o_avg_config, .o_word, .o_word_valid
);

/* File: asd_host_model.sv */
/*
 * Serial host model: frames of MSB-first bits on chip select, serial
 * clock and data. Assumes a 20 MHz reference clock to time the pins.
 */
`timescale 1ns/1ns
module asd_host_model (
    // reference clock
    input wire logic i_ref_clk,
    // serial pins
    output logic o_cs_n,
    output logic o_sclk,
    output logic o_din
);
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_din = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask : tick
    // bits go from v[15] down; four ref clocks a phase, 400 ns period
    task automatic xfer(input logic [15:0] v, input int n);
        tick(1);
        o_cs_n <= 1'b0;
        tick(4);
        for (int i = 0; i < n; i++) begin
            o_din <= v[15 - i];
            tick(4);
            o_sclk <= 1'b1;
            tick(4);
            o_sclk <= 1'b0;
        end
        tick(4);
        o_cs_n <= 1'b1;
        // released data line must not keep its last value
        o_din <= ~o_din;
        tick(8);
    endtask : xfer
endmodule : asd_host_model

/* File: tb.sv */
/*
 * Testbench for asd_setup_decode: serial frames from the host model,
 * result words driven directly, expectations from the rules.
 * Assumes the checker is bound in by its own file.
 */
`timescale 1ns/1ns
`include "asd_cfg.svh"
module tb;
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_ce = 1'b1;
    logic i_conv_valid = 1'b0;
    logic i_temp_valid = 1'b0;
    logic [11:0] i_conv_code = 12'h000;
    logic [11:0] i_temp_hi = 12'h000;
    logic [11:0] i_temp_lo = 12'h000;
    logic [3:0] i_conv_chan = 4'h0;
    wire logic i_cs_n;
    wire logic i_sclk;
    wire logic i_din;
    logic o_int_conv_clock, o_int_acq_timed, o_start_pin_is_start;
    logic o_sclk_conv_clock, o_ref_internal, o_ref_powered;
    logic o_ref_wake_needed, o_ref_neg_is_ref, o_avg_active;
    logic o_repeat_single, o_fifo_clear, o_soft_reset, o_word_valid;
    logic o_temp_req, o_conv_req;
    logic [1:0] o_scan_mode, o_avg_count_sel, o_scan_count_sel;
    logic [3:0] o_scan_chan;
    logic [7:0] o_unipolar_pairs, o_bipolar_pairs, o_setup_config;
    logic [7:0] o_avg_config, dec, s;
    logic [15:0] o_word;
    int n_fail = 0;
    int checked = 0;
    int n_clr = 0;
    int n_soft = 0;
    int n_conv = 0;

    asd_host_model asd_host_model_inst (.i_ref_clk, .o_cs_n(i_cs_n),
        .o_sclk(i_sclk), .o_din(i_din));
    asd_setup_decode asd_setup_decode_inst (.i_ref_clk, .i_rst, .i_ce,
        .i_cs_n, .i_sclk, .i_din, .o_int_conv_clock, .o_int_acq_timed,
        .o_start_pin_is_start, .o_sclk_conv_clock, .o_ref_internal,
        .o_ref_powered, .o_ref_wake_needed, .o_ref_neg_is_ref, .o_avg_active,
        .o_avg_count_sel, .o_scan_count_sel, .o_repeat_single,
        .o_scan_mode, .o_scan_chan, .o_temp_req, .o_conv_req,
        .o_unipolar_pairs, .o_bipolar_pairs, .o_fifo_clear, .o_soft_reset,
        .o_setup_config, .o_avg_config, .i_conv_valid, .i_conv_code,
        .i_conv_chan, .i_temp_valid, .i_temp_hi, .i_temp_lo, .o_word,
        .o_word_valid);

    assign dec = {o_sclk_conv_clock, o_int_conv_clock, o_start_pin_is_start,
        o_int_acq_timed, o_ref_internal, o_ref_powered, o_ref_wake_needed,
        o_ref_neg_is_ref};

    initial begin
        forever #25 i_ref_clk = ~i_ref_clk;
    end
    always @(posedge i_ref_clk) begin
        if (o_fifo_clear === 1'b1) n_clr++;
        if (o_soft_reset === 1'b1) n_soft++;
        if (o_conv_req === 1'b1) n_conv++;
    end

    // expected decode flags for a setup byte, same order as dec
    function automatic logic [7:0] dexp(input logic [7:0] v);
        return {v[5:4] == 2'b11, v[5:4] != 2'b11, !v[5], !v[4], !v[2],
            v[3:2] == 2'b10, v[3:2] == 2'b00, v[3:2] == 2'b11};
    endfunction : dexp
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask : chk
    task automatic results;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results
    task automatic wr(input logic [15:0] v, input int n);
        asd_host_model_inst.xfer(v, n);
    endtask : wr
    task automatic res(input logic t, input logic [11:0] a,
        input logic [11:0] b, input logic [3:0] ch);
        @(posedge i_ref_clk);
        i_temp_valid <= t;
        i_conv_valid <= !t;
        i_temp_hi <= a;
        i_conv_code <= a;
        i_temp_lo <= b;
        i_conv_chan <= ch;
        @(posedge i_ref_clk);
        i_temp_valid <= 1'b0;
        i_conv_valid <= 1'b0;
        #1 chk(16'(o_word_valid), 16'h0001);
    endtask : res

    initial begin
        #2000000;
        n_fail++;
        results;
    end

    initial begin
        repeat (16) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        chk(16'(o_setup_config), 16'h0020);
        chk(16'({o_unipolar_pairs, o_avg_config}), 16'h0000);
        chk(16'(dec), 16'(dexp(8'h20)));
        // every clock and reference mode, pair select 00 and 01
        for (int i = 0; i < 16; i++) begin
            s = {2'b01, i[3:0], 1'b0, i[0]};
            wr({s, 8'h00}, 8);
            chk(16'(o_setup_config), 16'(s));
            chk(16'(dec), 16'(dexp(s)));
            chk({o_unipolar_pairs, o_bipolar_pairs}, 16'h0000);
        end
        wr(16'h6281, 16);
        chk(16'(o_unipolar_pairs), 16'h0081);
        wr(16'h63C3, 16);
        chk(16'(o_bipolar_pairs), 16'h0042);
        // with pair select 00 the second byte is a fresh command
        wr(16'h603F, 16);
        chk(16'(o_avg_config), 16'h003F);
        chk(16'({o_avg_count_sel, o_scan_count_sel}), 16'h000F);
        chk(16'(o_avg_active), 16'h0001);
        chk(16'(o_unipolar_pairs), 16'h0081);
        wr(16'h7000, 8);
        chk(16'(o_avg_active), 16'h0000);
        wr(16'hAC00, 8);
        chk(16'({n_conv[3:0], o_temp_req, o_scan_mode, o_repeat_single,
            o_scan_chan}), 16'h0155);
        // a cut-short byte and a null-prefix byte leave setup alone
        wr(16'h6C00, 5);
        chk(16'(o_setup_config), 16'h0070);
        wr(16'h0F00, 8);
        chk(16'(o_setup_config), 16'h0070);
        // enable low: a whole frame goes unseen
        i_ce <= 1'b0;
        wr(16'h4000, 8);
        i_ce <= 1'b1;
        chk(16'(o_setup_config), 16'h0070);
        res(1'b1, 12'hA00, 12'h100, 4'h0);
        chk(o_word, {4'h0, 12'h900 - `ASD_TEMP_OFFSET});
        res(1'b0, 12'hFFF, 12'h000, 4'h0);
        chk(o_word, 16'h0FFF);
        res(1'b0, 12'h800, 12'h000, 4'h2);
        chk(o_word, 16'h0000);
        wr(16'h1800, 8);
        chk(16'(n_clr), 16'h0001);
        chk(16'(o_setup_config), 16'h0070);
        chk(16'(n_soft), 16'h0000);
        wr(16'h1000, 8);
        chk(16'(n_soft), 16'h0001);
        chk(16'(o_setup_config), 16'h0020);
        chk({o_unipolar_pairs, o_avg_config}, 16'h0000);
        chk(16'(o_bipolar_pairs), 16'h0000);
        results;
    end
endmodule : tb
